// [inc/rdo_defines.svh]
// Constants for the resettable divided oscillator output
`ifndef RDO_DEFINES_SVH
`define RDO_DEFINES_SVH

`define RDO_PRESCALE_LOG2   5'h0A
`define RDO_RATIO_STEP_LOG2 5'h03
`define RDO_CNT_W           31
`define RDO_MASTER_CYCLES   1
`define RDO_STARTUP_PERIODS 500
`define RDO_STARTUP_CYCLES  (`RDO_STARTUP_PERIODS * `RDO_MASTER_CYCLES)
`define RDO_FILTER_CYCLES   8

`define RDO_CTRL_OFS        4'h0
`define RDO_STATUS_OFS      4'h4
`define RDO_CTRL_OVR_BIT    0
`define RDO_CTRL_CODE_LSB   1
`define RDO_CTRL_RESET      8'h00

`endif

// [inc/rdo_pkg.sv]
// Types for the resettable divided oscillator output
package rdo_pkg;
  typedef logic [3:0] rdo_code_type;
  typedef logic [2:0] rdo_ratio_type;
  typedef enum logic [2:0] {
    RDO_ST_START = 3'h1,
    RDO_ST_KICK  = 3'h2,
    RDO_ST_RUN   = 3'h4
  } rdo_state_type;
endpackage

// [inc/rdo_code_if.sv]
// Divide code path between core and code filter
`timescale 1ns/1ps
interface rdo_code_if;
  logic [3:0] raw;
  logic [3:0] code;
  logic       valid;
  modport filt (input raw, output code, output valid);
  modport core (output raw, input code, input valid);
endinterface

// [rtl/rdo_sync2.sv]
// Two-stage synchroniser
`timescale 1ns/1ps
module rdo_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// [rtl/rdo_code_filter.sv]
// Divide code stability filter
`timescale 1ns/1ps
`include "rdo_defines.svh"
module rdo_code_filter #(
  parameter int FILT = `RDO_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  // Code path
  rdo_code_if.filt  cif
);
  logic [3:0] cand_q;
  logic [3:0] cnt_q;
  logic [3:0] code_q;
  logic       valid_q;

  assign cif.code  = code_q;
  assign cif.valid = valid_q;

  // Candidate must hold for FILT cycles before use
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cand_q <= 4'h0;
      cnt_q  <= 4'h0;
    end else if (cif.raw != cand_q) begin
      cand_q <= cif.raw;
      cnt_q  <= 4'h0;
    end else if (cnt_q != 4'(FILT - 1)) begin
      cnt_q  <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      code_q  <= 4'h0;
      valid_q <= 1'b0;
    end else if (cif.raw == cand_q && cnt_q == 4'(FILT - 1)) begin
      code_q  <= cand_q;
      valid_q <= 1'b1;
    end
  end
endmodule

// [rtl/rdo_core.sv]
// Resettable divided oscillator output core
`timescale 1ns/1ps
`include "rdo_defines.svh"
module rdo_core #(
  parameter int STARTUP = `RDO_STARTUP_CYCLES,
  parameter int FILT    = `RDO_FILTER_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_reset_n,
  // Divide code from converter
  input  wire rdo_pkg::rdo_code_type i_divide_code,
  // Output reset pin
  input  wire logic                i_out_reset,
  // Register port
  input  wire logic [3:0]          i_addr,
  input  wire logic [7:0]          i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [7:0]          o_rdata,
  // Oscillator output
  output logic                     o_out,
  output logic                     o_polarity_bit
);
  import rdo_pkg::*;

  rdo_code_if cif ();

  rdo_state_type   state_q;
  logic [8:0]      start_cnt_q;
  logic [`RDO_CNT_W-1:0] cnt_q;
  logic            latch_q;
  logic [7:0]      ctrl_q;
  logic            rst_pin_s;
  logic            polarity_bit;
  rdo_ratio_type   ratio_sel;
  logic [4:0]      half_exp;
  logic            all_ones;
  logic            tick_rise;
  logic            tick_fall;
  logic            rst_act_s;
  logic            rst_act_raw;
  logic            start_done;

  // Ratio exponent, mirrored for high codes
  function automatic rdo_ratio_type rdo_ratio_of(input rdo_code_type c);
    rdo_ratio_of = c[3] ? ~c[2:0] : c[2:0];
  endfunction

  // Half-period exponent: prescale/2 times ratio
  function automatic logic [4:0] rdo_half_exp(input rdo_ratio_type k);
    rdo_half_exp = `RDO_PRESCALE_LOG2 - 5'h01
                 + `RDO_RATIO_STEP_LOG2 * {2'h0, k};
  endfunction

  // Mask of counter bits below the half-period bit
  function automatic logic [`RDO_CNT_W-1:0] rdo_mask(
    input logic [4:0] e
  );
    rdo_mask = ({{(`RDO_CNT_W-1){1'b0}}, 1'b1} << e) - 1'b1;
  endfunction

  // Reset pin synchroniser
  rdo_sync2 #(
    .W (1)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_out_reset),
    .o_sync    (rst_pin_s)
  );

  // Software may override the converter code
  assign cif.raw = ctrl_q[`RDO_CTRL_OVR_BIT] ?
                   ctrl_q[`RDO_CTRL_CODE_LSB +: 4] : i_divide_code;

  rdo_code_filter #(
    .FILT (FILT)
  ) u_filt (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .cif       (cif)
  );

  assign polarity_bit       = cif.code[3];
  assign ratio_sel = rdo_ratio_of(cif.code);
  assign half_exp  = rdo_half_exp(ratio_sel);
  assign all_ones  = (cnt_q & rdo_mask(half_exp)) == rdo_mask(half_exp);
  assign tick_rise = all_ones && !cnt_q[half_exp];
  assign tick_fall = all_ones && cnt_q[half_exp];
  assign rst_act_s   = rst_pin_s ^ polarity_bit;
  assign rst_act_raw = i_out_reset ^ polarity_bit;
  assign start_done  = (start_cnt_q == 9'(STARTUP - 1)) && cif.valid;
  assign o_polarity_bit = polarity_bit;

  // Free-running prescaler and divider chain
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Start-up interval counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      start_cnt_q <= 9'h000;
    end else if (start_cnt_q != 9'(STARTUP - 1)) begin
      start_cnt_q <= start_cnt_q + 9'h001;
    end
  end

  // Start-up sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_q <= RDO_ST_START;
    end else begin
      case (state_q)
        RDO_ST_START: begin
          if (start_done) begin
            state_q <= RDO_ST_KICK;
          end
        end
        RDO_ST_KICK: begin
          state_q <= RDO_ST_RUN;
        end
        RDO_ST_RUN: begin
          state_q <= RDO_ST_RUN;
        end
        default: begin
          state_q <= RDO_ST_START;
        end
      endcase
    end
  end

  // Output state latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      latch_q <= 1'b0;
    end else if (state_q == RDO_ST_START) begin
      latch_q <= 1'b0;
    end else if (rst_act_s) begin
      latch_q <= 1'b0;
    end else if (state_q == RDO_ST_KICK && polarity_bit) begin
      latch_q <= 1'b1;
    end else if (tick_rise) begin
      latch_q <= 1'b1;
    end else if (tick_fall) begin
      latch_q <= 1'b0;
    end
  end

  // Output buffer with pin gating
  always_comb begin
    if (state_q == RDO_ST_START) begin
      o_out = 1'b0;
    end else begin
      o_out = polarity_bit ^ (latch_q & ~rst_act_raw);
    end
  end

  // Control register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= `RDO_CTRL_RESET;
    end else if (i_wr && i_addr == `RDO_CTRL_OFS) begin
      ctrl_q <= {3'h0, i_wdata[4:0]};
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == `RDO_CTRL_OFS) begin
      o_rdata <= ctrl_q;
    end else if (i_rd && i_addr == `RDO_STATUS_OFS) begin
      o_rdata <= {cif.code, latch_q, o_out, polarity_bit,
                  state_q != RDO_ST_START};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Checks

  sequence s_startup_end;
    state_q == RDO_ST_START ##1 state_q == RDO_ST_KICK;
  endsequence

  sequence s_run_idle;
    state_q == RDO_ST_RUN && !rst_act_s && !tick_rise;
  endsequence

  startup_low_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q == RDO_ST_START |-> !o_out
  ) else $error("output not low during start-up");

  startup_len_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q == RDO_ST_KICK |-> start_cnt_q == 9'(STARTUP - 1)
  ) else $error("start-up interval too short");

  pol_map_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !$stable(o_polarity_bit) |-> o_polarity_bit == $past(cif.raw[3])
  ) else $error("polarity not code MSB");

  ratio_map_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    cif.code == 4'h9 |-> half_exp == 5'h1B
  ) else $error("mirrored ratio wrong");

  prescale_align_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(latch_q) && $past(state_q) == RDO_ST_RUN
      |-> $past(cnt_q[8:0]) == 9'h1FF
  ) else $error("latch rose off prescaler boundary");

  reset_low_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q != RDO_ST_START && !polarity_bit && i_out_reset |-> !o_out
  ) else $error("active-high reset did not force low");

  reset_high_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q != RDO_ST_START && polarity_bit && !i_out_reset |-> o_out
  ) else $error("active-low reset did not force high");

  buffer_inv_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q == RDO_ST_RUN && !rst_act_raw |-> o_out == (polarity_bit ^ latch_q)
  ) else $error("buffer polarity wrong");

  no_early_rise_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_run_idle |=> !$rose(latch_q)
  ) else $error("latch set without oscillator tick");

  held_off_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    rst_act_s |=> !latch_q
  ) else $error("active reset did not clear latch");

  chain_runs_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    rst_act_s |=> cnt_q == $past(cnt_q) + 1'b1
  ) else $error("divider chain stalled by reset");

  kick_fall_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_startup_end ##0 (polarity_bit && !rst_act_s) |=> latch_q
  ) else $error("inverted start-up did not fall");

  skip_first_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_startup_end ##0 (!polarity_bit && rst_act_s) |=> !latch_q
  ) else $error("pulse not skipped under reset");

  half_period_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    state_q == RDO_ST_RUN && !rst_act_s && tick_fall |=> !latch_q
  ) else $error("latch did not toggle at half period");

  code_stable_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    cif.code != $past(cif.code) |-> $past(cif.raw, 2) == cif.code
  ) else $error("unfiltered code applied");

endmodule

// [bench/rdo_sys_model.sv]
// System-side model that drives the output reset pin
`timescale 1ns/1ps
module rdo_sys_model (
  // Clock
  input  wire logic i_sys_clk,
  // Request from the bench to hold the output off
  input  wire logic i_hold,
  input  wire logic i_polarity_bit,
  // Output reset pin
  output logic      o_out_reset
);
  initial o_out_reset = 1'b0;
  // Inactive level equals polarity, active level its inverse
  always @(posedge i_sys_clk) begin
    o_out_reset <= i_hold ? ~i_polarity_bit : i_polarity_bit;
  end
endmodule

// [bench/tb_top.sv]
// Self-checking testbench for the divided oscillator output core
`timescale 1ns/1ps
module tb_top;
  import rdo_pkg::*;
  logic         i_sys_clk     = 1'b0;
  logic         i_reset_n     = 1'b0;
  rdo_code_type i_divide_code = 4'h0;
  logic         hold_req      = 1'b0;
  logic         i_out_reset;
  logic [3:0]   i_addr        = 4'h0;
  logic [7:0]   i_wdata       = 8'h00;
  logic         i_wr          = 1'b0;
  logic         i_rd          = 1'b0;
  logic [7:0]   o_rdata;
  logic         o_out;
  logic         o_polarity_bit;
  int           fails         = 0;
  int           check_count   = 0;
  int           cyc           = 0;

  always #20 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  rdo_core #(.STARTUP(20), .FILT(8)) dut (
    .i_sys_clk      (i_sys_clk),
    .i_reset_n      (i_reset_n),
    .i_divide_code  (i_divide_code),
    .i_out_reset    (i_out_reset),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .o_out          (o_out),
    .o_polarity_bit (o_polarity_bit)
  );

  rdo_sys_model sys (
    .i_sys_clk      (i_sys_clk),
    .i_hold         (hold_req),
    .i_polarity_bit (o_polarity_bit),
    .o_out_reset    (i_out_reset)
  );

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      fails++;
    end
  endtask

  task automatic wait_out(input logic v, output int t);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    while (o_out !== v) begin
      n++;
      if (n > 40000) begin
        $display("[ERR] o_out wait expected %0h seen %0h", v, o_out);
        fails++;
        complete_run();
      end
      @(negedge i_sys_clk);
    end
    t = cyc;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
  endtask

  task automatic set_code(input rdo_code_type c);
    @(posedge i_sys_clk);
    i_divide_code <= c;
    repeat (12) @(posedge i_sys_clk);
  endtask

  // Power-on start-up, optionally inverted
  task automatic t_start(input rdo_code_type c);
    int t0, t1, t2;
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    i_divide_code <= c;
    repeat (5) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t0 = cyc;
    wait_out(1'b1, t1);
    chk("startup low", 1, (t1 - t0) >= 20);
    chk("polarity", c[3], o_polarity_bit);
    if (c[3]) begin
      wait_out(1'b0, t2);
      chk("kick width", 1, t2 - t1);
    end
  endtask

  // Polarity of every code, and a short blip that is ignored
  task automatic t_pol();
    logic [4:0] c;
    for (c = 5'h00; c < 5'h10; c++) begin
      set_code(c[3:0]);
      chk("code polarity", c[3], o_polarity_bit);
    end
    set_code(4'h0);
    i_divide_code <= 4'h8;
    repeat (3) @(posedge i_sys_clk);
    i_divide_code <= 4'h0;
    repeat (12) @(posedge i_sys_clk);
    chk("blip ignored", 0, o_polarity_bit);
  endtask

  // Half period and full period for a code
  task automatic t_width(input rdo_code_type c, input int half);
    int t0, t1, t2;
    set_code(c);
    wait_out(~c[3], t0);
    wait_out(c[3], t0);
    wait_out(~c[3], t1);
    wait_out(c[3], t2);
    chk("half period", half, t1 - t0);
    chk("full period", 2 * half, t2 - t0);
  endtask

  // Reset pin held over one pulse, then released
  task automatic t_hold(input rdo_code_type c);
    int t0, t1, bad;
    set_code(c);
    bad = 0;
    wait_out(c[3], t0);
    wait_out(~c[3], t0);
    repeat (100) @(posedge i_sys_clk);
    hold_req <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("reset level", c[3], o_out);
    repeat (1500) begin
      @(negedge i_sys_clk);
      if (o_out !== c[3]) bad++;
    end
    chk("held output", 0, bad);
    @(posedge i_sys_clk);
    hold_req <= 1'b0;
    wait_out(~c[3], t1);
    chk("phase kept", 2048, t1 - t0);
  endtask

  // Start-up with the reset pin active: pulses skipped, phase kept
  task automatic t_start_held(input rdo_code_type c);
    int t0, t1, bad;
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    i_divide_code <= c;
    hold_req <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t0 = cyc;
    bad = 0;
    repeat (3000) begin
      @(negedge i_sys_clk);
      if (cyc - t0 > 40 && o_out !== c[3]) bad++;
    end
    chk("start held", 0, bad);
    @(posedge i_sys_clk);
    hold_req <= 1'b0;
    wait_out(~c[3], t1);
    chk("first edge phase", 513, (t1 - t0) % 1024);
  endtask

  // Register port: reset value, masks, override, unmapped place
  task automatic t_regs();
    logic [7:0] d;
    rd(4'h0, d);
    chk("ctrl reset", 8'h00, d);
    wr(4'h0, 8'hFF);
    rd(4'h0, d);
    chk("ctrl mask", 8'h1F, d);
    repeat (12) @(posedge i_sys_clk);
    rd(4'h4, d);
    chk("status code", 4'hF, d[7:4]);
    chk("status pol", 1, d[1]);
    rd(4'h8, d);
    chk("unmapped", 8'h00, d);
    wr(4'h0, 8'h00);
    repeat (12) @(posedge i_sys_clk);
    chk("override off", 0, o_polarity_bit);
  endtask

  initial begin
    t_start(4'h0);
    t_regs();
    t_pol();
    t_width(4'h0, 512);
    t_width(4'h1, 4096);
    t_width(4'hE, 4096);
    t_width(4'hF, 512);
    t_hold(4'h0);
    t_start(4'hF);
    t_hold(4'hF);
    t_start_held(4'h0);
    t_start_held(4'hF);
    complete_run();
  end
endmodule
